// [verilog/rss_top.sv]
/*
 * Reset source sequencer: merges pin, address trap, watchdog and system
 * clock faults into one reset with a flash stabilisation stretch.
 * Assumes aclk is the high-frequency clock, the reset pin is asynchronous,
 * and fetch and watchdog inputs come from logic on aclk.
 */
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
//
// Function
// - A reset pin held low for twelve clock periods resets the device, and the outside must hold it that long.
// - After the pin returns high, reset stays asserted for 1024 clock periods before release.
// - On release the CPU fetches its start vector from the two top bytes of the address space.
// - A fetch from on-chip RAM with RAM trapping enabled raises an address trap reset plus the stabilisation reset.
// - A fetch from the special register region always traps, whatever the RAM trap enable.
// - An address trap reset lasts at most 24 plus 1024 clock periods.
// - An address trap takes either the reset or the interrupt action as selected, never both.
// - Clearing both oscillator enables in one write raises a system clock reset.
// - Clearing the high oscillator enable while the low clock is not selected raises a system clock reset.
// - Clearing the low oscillator enable while the low clock is selected raises a system clock reset.
// - On a system clock reset the oscillator that was to be stopped keeps running.
// - A system clock reset also runs the stabilisation reset, at most 24 plus 1024 clock periods.
// - The data buffer region is decoded as its own window apart from the special register region.
// - The stabilisation length comes from an eleven-stage counter cleared at the start of every stabilisation stretch.
// - The internal fault sources may hold reset for up to 24 clock periods at power-on.
`timescale 1ns/100ps
module rss_top #(
	parameter int PIN_LOW_CYC_P = rss_pkg::PIN_LOW_CYC,
	parameter int STAB_CYC_P    = rss_pkg::STAB_CYC,
	parameter int FAULT_CYC_P   = rss_pkg::FAULT_CYC
) (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic                      ce,
	input  wire logic                      rst_pin_n,
	input  wire logic                      wdog_req,
	input  wire rss_pkg::rss_fetch_t       fetch,
	output logic                           cpu_reset_n,
	output logic                           boot_fetch,
	output logic [15:0]                    boot_vector,
	output logic                           trap_irq,
	output logic                           high_osc_run,
	output logic                           low_osc_run,
	output logic                           sys_clock_sel,
	output logic                           sfr_hit,
	output logic                           dbr_hit,
	input  wire logic [rss_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [rss_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready
);
	import rss_pkg::*;

	// Refuse counts the counters cannot hold
	if (STAB_CYC_P < 1 || STAB_CYC_P > (1 << CNT_W) || FAULT_CYC_P < 1 || FAULT_CYC_P > STAB_CYC_P
		|| PIN_LOW_CYC_P < 1 || PIN_LOW_CYC_P >= (1 << LOW_W)) begin : g_bad_param
		$error("rss_top: count parameter out of range");
	end

	localparam logic [CNT_W-1:0] STAB_LAST  = CNT_W'(STAB_CYC_P - 1);
	localparam logic [CNT_W-1:0] FAULT_LAST = CNT_W'(FAULT_CYC_P - 1);
	localparam logic [LOW_W-1:0] LOW_LAST   = LOW_W'(PIN_LOW_CYC_P - 1);
	localparam rss_regs_t RST_STATE = '{pin_meta: 1'b1, pin_sync: 1'b1, seq: SEQ_FAULT,
		ctrl: CTRL_RST, sysctl: SYSCTL_RST, cause: 5'h10, default: '0};

	rss_regs_t   q;
	rss_regs_t   d;
	logic        running;
	logic        pin_low;
	logic        trap_hit;
	logic        trap_rst;
	logic        wr_fire;
	logic        sys_wr;
	logic        sys_bad;
	logic        clr_high;
	logic        clr_low;
	rss_sysctl_t sys_new;

	// Inclusive address window check
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Register read mux
	function automatic logic [31:0] reg_read(input rss_regs_t s, input logic [AXI_AW-1:0] a);
		reg_read = 32'h0;
		case (a)
			REG_CTRL:   reg_read = {30'h0, s.ctrl};
			REG_SYSCTL: reg_read = {29'h0, s.sysctl};
			REG_STATUS: reg_read = {26'h0, s.cause, ~s.reset_n};
			default:    reg_read = 32'h0;
		endcase
	endfunction

	function automatic logic reg_known(input logic [AXI_AW-1:0] a);
		reg_known = (a == REG_CTRL) || (a == REG_SYSCTL) || (a == REG_STATUS);
	endfunction

	// Fetch trap and oscillator misconfiguration detection
	always_comb begin
		running  = (q.seq == SEQ_RUN);
		pin_low  = ~q.pin_sync;
		trap_hit = fetch.valid && (in_range(fetch.addr, SFR_LO, SFR_HI)
			|| (q.ctrl[CTRL_RAM_TRAP_BIT] && in_range(fetch.addr, RAM_LO, RAM_HI)));
		trap_rst = running && trap_hit && ~q.ctrl[CTRL_TRAP_IRQ_BIT];
		wr_fire  = q.aw_got && q.w_got && ~q.bvalid;
		sys_wr   = wr_fire && (q.aw_addr == REG_SYSCTL) && q.w_strb[0];
		sys_new  = rss_sysctl_t'(q.w_data[2:0]);
		clr_high = q.sysctl.high_osc_enable && ~sys_new.high_osc_enable;
		clr_low  = q.sysctl.low_osc_enable && ~sys_new.low_osc_enable;
		sys_bad  = sys_wr && ((clr_high && clr_low)
			|| (clr_high && ~q.sysctl.system_clock_select)
			|| (clr_low && q.sysctl.system_clock_select));
	end

	// Next-state logic for the whole block
	always_comb begin
		d = q;
		if (ce) begin
			// Pin synchroniser
			d.pin_meta = rst_pin_n;
			d.pin_sync = q.pin_meta;
			d.boot     = 1'b0;
			d.trap_irq = running && trap_hit && q.ctrl[CTRL_TRAP_IRQ_BIT];
			d.sfr_hit  = fetch.valid && in_range(fetch.addr, SFR_LO, SFR_HI);
			d.dbr_hit  = fetch.valid && in_range(fetch.addr, DBR_LO, DBR_HI);
			d.low_cnt  = (running && pin_low && q.low_cnt != LOW_LAST) ? q.low_cnt + 1'b1 : '0;

			// Reset sequencer
			case (q.seq)
				SEQ_FAULT: begin
					if (pin_low) begin
						d.seq = SEQ_HOLD;
					end else if (q.cnt == FAULT_LAST) begin
						d.seq = SEQ_STAB;
						d.cnt = '0;
					end else begin
						d.cnt = q.cnt + 1'b1;
					end
				end
				SEQ_HOLD: begin
					if (!pin_low) begin
						d.seq = SEQ_STAB;
						d.cnt = '0;
					end
				end
				SEQ_STAB: begin
					if (pin_low) begin
						d.seq = SEQ_HOLD;
					end else if (q.cnt == STAB_LAST) begin
						d.seq  = SEQ_RUN;
						d.boot = 1'b1;
					end else begin
						d.cnt = q.cnt + 1'b1;
					end
				end
				SEQ_RUN: begin
					if (pin_low && q.low_cnt == LOW_LAST) begin
						d.seq = SEQ_HOLD;
					end else if (trap_rst || wdog_req || sys_bad) begin
						d.seq = SEQ_FAULT;
						d.cnt = '0;
					end
				end
				default: begin
					d.seq = SEQ_FAULT;
					d.cnt = '0;
				end
			endcase
			d.reset_n = (d.seq == SEQ_RUN);

			// AXI write channel capture
			if (s_axi_awvalid && s_axi_awready) begin
				d.aw_got  = 1'b1;
				d.aw_addr = s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				d.w_got  = 1'b1;
				d.w_data = s_axi_wdata;
				d.w_strb = s_axi_wstrb;
			end
			if (q.bvalid && s_axi_bready) begin
				d.bvalid = 1'b0;
			end
			// Register write once both halves are in
			if (wr_fire) begin
				d.aw_got = 1'b0;
				d.w_got  = 1'b0;
				d.bvalid = 1'b1;
				d.bresp  = reg_known(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
				if (q.aw_addr == REG_CTRL && q.w_strb[0]) begin
					d.ctrl = q.w_data[1:0];
				end
				if (sys_wr) begin
					// A bad write keeps both oscillators as they were
					d.sysctl = sys_bad ? q.sysctl : sys_new;
				end
				if (q.aw_addr == REG_STATUS && q.w_strb[0]) begin
					d.cause = q.cause & ~rss_cause_t'(q.w_data[STAT_CAUSE_LSB +: 5]);
				end
			end
			// Cause flags; a new event wins over a clear
			if (running && pin_low && q.low_cnt == LOW_LAST) begin
				d.cause.pin = 1'b1;
			end
			if (running && trap_rst) begin
				d.cause.trap = 1'b1;
			end
			if (running && wdog_req) begin
				d.cause.wdog = 1'b1;
			end
			if (running && sys_bad) begin
				d.cause.sysclk = 1'b1;
			end

			// AXI read channel
			if (q.rvalid && s_axi_rready) begin
				d.rvalid = 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				d.rvalid = 1'b1;
				d.rdata  = reg_read(q, s_axi_araddr);
				d.rresp  = reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= RST_STATE;
		end else begin
			q <= d;
		end
	end

	// Outputs
	assign cpu_reset_n   = q.reset_n;
	assign boot_fetch    = q.boot;
	assign boot_vector   = VEC_LO;
	assign trap_irq      = q.trap_irq;
	assign high_osc_run  = q.sysctl.high_osc_enable;
	assign low_osc_run   = q.sysctl.low_osc_enable;
	assign sys_clock_sel = q.sysctl.system_clock_select;
	assign sfr_hit       = q.sfr_hit;
	assign dbr_hit       = q.dbr_hit;
	assign s_axi_awready = ~q.aw_got && ~q.bvalid;
	assign s_axi_wready  = ~q.w_got && ~q.bvalid;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = ~q.rvalid;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;

	// Helper: length of the fault stretch
	logic [CNT_W:0] fault_len;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_len <= '0;
		end else if (q.seq != SEQ_FAULT) begin
			fault_len <= '0;
		end else if (ce) begin
			fault_len <= fault_len + 1'b1;
		end
	end

	a_pin_low_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && q.seq == SEQ_RUN && pin_low && q.low_cnt == LOW_LAST) |=> !cpu_reset_n)
		else $error("pin low long enough did not reset");
	a_pin_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		(q.seq == SEQ_HOLD && pin_low) |=> !cpu_reset_n)
		else $error("reset released while pin low");
	a_stab_length: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(cpu_reset_n) |-> ($past(q.cnt) == STAB_LAST && $past(q.seq) == SEQ_STAB))
		else $error("release not after full stabilisation count");
	a_boot_vector: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(cpu_reset_n) |-> (boot_fetch && boot_vector == VEC_LO))
		else $error("no vector fetch at release");
	a_sfr_trap: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && running && fetch.valid && fetch.addr <= SFR_HI && !q.ctrl[CTRL_TRAP_IRQ_BIT]
			&& !(pin_low && q.low_cnt == LOW_LAST))
		|=> (!cpu_reset_n && q.seq == SEQ_FAULT && q.cnt == '0))
		else $error("register region fetch did not trap");
	a_fault_bound: assert property (@(posedge aclk) disable iff (!aresetn)
		fault_len <= (CNT_W + 1)'(FAULT_CYC_P))
		else $error("fault stretch too long");
	a_trap_one_act: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && running && trap_hit && q.ctrl[CTRL_TRAP_IRQ_BIT]) |=> (trap_irq && cpu_reset_n))
		else $error("interrupt mode trap misbehaved");
	a_osc_kept: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && running && sys_bad) |=> (high_osc_run == $past(high_osc_run)
			&& low_osc_run == $past(low_osc_run) && !cpu_reset_n))
		else $error("oscillator stopped on clock fault");
	a_dbr_window: assert property (@(posedge aclk) disable iff (!aresetn)
		dbr_hit |-> (!sfr_hit && $past(fetch.addr) >= DBR_LO))
		else $error("data buffer decode wrong");

	// Trap, clock fault and sequencer step checks
	a_ram_trap: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && running && fetch.valid && fetch.addr >= RAM_LO && fetch.addr <= RAM_HI
			&& q.ctrl[CTRL_RAM_TRAP_BIT] && !q.ctrl[CTRL_TRAP_IRQ_BIT] && !(pin_low && q.low_cnt == LOW_LAST))
		|=> (!cpu_reset_n && q.seq == SEQ_FAULT && q.cause.trap))
		else $error("enabled RAM fetch did not trap");
	a_ram_no_trap: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && running && fetch.valid && fetch.addr >= RAM_LO && fetch.addr <= RAM_HI
			&& !q.ctrl[CTRL_RAM_TRAP_BIT] && !wdog_req && !sys_bad && !pin_low) |=> cpu_reset_n)
		else $error("RAM fetch trapped while trapping disabled");
	a_both_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && running && wr_fire && q.aw_addr == REG_SYSCTL && q.w_strb[0] && q.sysctl.high_osc_enable
			&& q.sysctl.low_osc_enable && !q.w_data[0] && !q.w_data[1])
		|=> (!cpu_reset_n && high_osc_run && low_osc_run && q.cause.sysclk))
		else $error("clearing both oscillators did not reset");
	a_high_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && running && wr_fire && q.aw_addr == REG_SYSCTL && q.w_strb[0] && q.sysctl.high_osc_enable
			&& !q.w_data[0] && !q.sysctl.system_clock_select)
		|=> (!cpu_reset_n && high_osc_run && q.cause.sysclk))
		else $error("clearing the running high oscillator did not reset");
	a_low_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && running && wr_fire && q.aw_addr == REG_SYSCTL && q.w_strb[0] && q.sysctl.low_osc_enable
			&& !q.w_data[1] && q.sysctl.system_clock_select)
		|=> (!cpu_reset_n && low_osc_run && q.cause.sysclk))
		else $error("clearing the running low oscillator did not reset");
	a_wdog_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && running && wdog_req) |=> (!cpu_reset_n && q.cause.wdog))
		else $error("watchdog request did not reset");
	a_fault_to_stab: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && q.seq == SEQ_FAULT && !pin_low && q.cnt == FAULT_LAST) |=> (q.seq == SEQ_STAB && q.cnt == '0))
		else $error("fault stretch did not hand over to stabilisation");
	a_stab_step: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && q.seq == SEQ_STAB && !pin_low && q.cnt != STAB_LAST)
		|=> (q.seq == SEQ_STAB && q.cnt == $past(q.cnt) + 1'b1))
		else $error("stabilisation counter did not step");
	a_pin_cause: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && running && pin_low && q.low_cnt == LOW_LAST) |=> q.cause.pin)
		else $error("pin reset cause not recorded");
	a_boot_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && boot_fetch) |=> !boot_fetch)
		else $error("vector fetch pulse longer than one cycle");
endmodule

// [shared/rss_pkg.sv]
/*
 * Shared constants and types for the reset source sequencer.
 * Assumes aclk is the high-frequency clock of the device.
 */
package rss_pkg;
	// Clock periods in picoseconds; aclk runs at 100 MHz and is the high-frequency clock
	localparam int CLK_PERIOD_PS = 10000;
	localparam int HFC_PERIOD_PS = 10000;
	// Times in high-frequency clock periods, as specified
	localparam int PIN_LOW_HFC   = 12;
	localparam int STAB_HFC      = 1024;
	localparam int FAULT_HFC     = 24;
	// Cycle counts: least times round up, longest round down
	localparam int PIN_LOW_CYC   = (PIN_LOW_HFC * HFC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STAB_CYC      = (STAB_HFC * HFC_PERIOD_PS) / CLK_PERIOD_PS;
	localparam int FAULT_CYC     = (FAULT_HFC * HFC_PERIOD_PS) / CLK_PERIOD_PS;
	localparam int CNT_W         = 11;
	localparam int LOW_W         = 4;
	// Fetch address map
	localparam logic [15:0] SFR_LO  = 16'h0000;
	localparam logic [15:0] SFR_HI  = 16'h003F;
	localparam logic [15:0] DBR_LO  = 16'h1F80;
	localparam logic [15:0] DBR_HI  = 16'h1FFF;
	localparam logic [15:0] RAM_LO  = 16'h0040;
	localparam logic [15:0] RAM_HI  = 16'h083F;
	localparam logic [15:0] VEC_LO  = 16'hFFFE;
	localparam logic [15:0] VEC_HI  = 16'hFFFF;
	// Register map
	localparam int          AXI_AW      = 12;
	localparam logic [11:0] REG_CTRL    = 12'h000;
	localparam logic [11:0] REG_SYSCTL  = 12'h004;
	localparam logic [11:0] REG_STATUS  = 12'h008;
	localparam int          CTRL_RAM_TRAP_BIT = 0;
	localparam int          CTRL_TRAP_IRQ_BIT = 1;
	localparam int          STAT_ACTIVE_BIT   = 0;
	localparam int          STAT_CAUSE_LSB    = 1;
	localparam logic [1:0]  CTRL_RST    = 2'h0;
	localparam logic [2:0]  SYSCTL_RST  = 3'h1;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SEQ_FAULT = 2'b00,
		SEQ_HOLD  = 2'b01,
		SEQ_STAB  = 2'b10,
		SEQ_RUN   = 2'b11
	} rss_seq_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} rss_fetch_t;

	// system_control_two: bit2 select, bit1 low osc, bit0 high osc
	typedef struct packed {
		logic system_clock_select;
		logic low_osc_enable;
		logic high_osc_enable;
	} rss_sysctl_t;

	typedef struct packed {
		logic power;
		logic sysclk;
		logic wdog;
		logic trap;
		logic pin;
	} rss_cause_t;

	typedef struct packed {
		logic              pin_meta;
		logic              pin_sync;
		rss_seq_t          seq;
		logic [CNT_W-1:0]  cnt;
		logic [LOW_W-1:0]  low_cnt;
		logic [1:0]        ctrl;
		rss_sysctl_t       sysctl;
		rss_cause_t        cause;
		logic              reset_n;
		logic              boot;
		logic              trap_irq;
		logic              sfr_hit;
		logic              dbr_hit;
		logic              aw_got;
		logic [AXI_AW-1:0] aw_addr;
		logic              w_got;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
	} rss_regs_t;
endpackage

// [dv/rss_partner.sv]
/*
 * Far-side model: external reset pin source and CPU fetch port.
 * Assumes the bench calls its tasks; each starts at a rising edge of aclk.
 */
`timescale 1ns/100ps
module rss_partner (
	input  wire logic           aclk,
	output logic                rst_pin_n,
	output rss_pkg::rss_fetch_t fetch
);
	import rss_pkg::*;
	// Pin idles high through its pull-up, fetch port idle
	initial begin
		rst_pin_n = 1'b1;
		fetch     = {1'b0, 16'h5A5A};
	end
	// Pin held low a whole number of cycles
	task automatic pin_low(input int n);
		@(posedge aclk);
		rst_pin_n <= 1'b0;
		repeat (n) @(posedge aclk);
		rst_pin_n <= 1'b1;
	endtask
	// One fetch for one cycle; address scrambled once released
	task automatic fetch_one(input logic [15:0] a);
		@(posedge aclk);
		fetch <= {1'b1, a};
		@(posedge aclk);
		fetch <= {1'b0, ~a};
	endtask
endmodule

// [dv/rss_top_tb.sv]
/*
 * Self-checking bench for the reset source sequencer.
 * Assumes short stretch parameters and an AXI4-Lite master of its own.
 */
`timescale 1ns/100ps
module rss_top_tb;
	import rss_pkg::*;
	localparam int STAB = 16;
	localparam int FLT  = 4;
	typedef struct packed {
		logic        wr;
		logic [15:0] v;
		logic        rst;
		logic [2:0]  e;
	} rss_row_t;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, wdog_req = 1'b0;
	logic rst_pin_n, cpu_reset_n, boot_fetch, trap_irq, high_osc_run, low_osc_run, sys_clock_sel, sfr_hit, dbr_hit;
	logic [15:0] boot_vector;
	rss_fetch_t  fetch;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] d;
	logic [2:0]  got;
	logic        irq;
	int          bad_count = 0, num_checks = 0, cyc = 0, n;
	rss_row_t rows [16] = '{
		{1'b0, 16'h0000, 1'b0, 3'h5}, {1'b0, 16'h003F, 1'b0, 3'h5}, {1'b0, 16'h0040, 1'b0, 3'h1},
		{1'b0, 16'h083F, 1'b0, 3'h1}, {1'b0, 16'h0840, 1'b0, 3'h0}, {1'b0, 16'h1F80, 1'b0, 3'h2},
		{1'b0, 16'h1FFF, 1'b0, 3'h2}, {1'b0, 16'h2000, 1'b0, 3'h0}, {1'b1, 16'h0003, 1'b0, 3'h6},
		{1'b1, 16'h0001, 1'b0, 3'h4}, {1'b1, 16'h0003, 1'b0, 3'h6}, {1'b1, 16'h0002, 1'b1, 3'h6},
		{1'b1, 16'h0007, 1'b0, 3'h7}, {1'b1, 16'h0005, 1'b1, 3'h7}, {1'b1, 16'h0003, 1'b0, 3'h6},
		{1'b1, 16'h0000, 1'b1, 3'h6}};
	rss_top #(.STAB_CYC_P(STAB), .FAULT_CYC_P(FLT)) dut (
		.aclk, .aresetn, .ce, .rst_pin_n, .wdog_req, .fetch, .cpu_reset_n, .boot_fetch, .boot_vector,
		.trap_irq, .high_osc_run, .low_osc_run, .sys_clock_sel, .sfr_hit, .dbr_hit,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	rss_partner part (.aclk(aclk), .rst_pin_n(rst_pin_n), .fetch(fetch));
	// Clock and hang guard
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Write: address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw, w, b;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge aclk);
			aw = s_axi_awvalid & s_axi_awready;
			w  = s_axi_wvalid & s_axi_wready;
			b  = s_axi_bvalid & s_axi_bready;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ar, rv;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		rv = 1'b0;
		while (!rv) begin
			@(negedge aclk);
			ar = s_axi_arvalid & s_axi_arready;
			rv = s_axi_rvalid & s_axi_rready;
			v  = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask
	// Either a full reset sequence with its length bounded, or no reset at all
	task automatic settle(input logic rst);
		logic lo;
		lo = 1'b0;
		n  = 0;
		if (rst) begin
			do begin
				@(negedge aclk);
				n++;
				if (cpu_reset_n === 1'b0) lo = 1'b1;
			end while (!(lo && cpu_reset_n === 1'b1) && n < 3000);
			check(lo, 1'b1);
			check(n >= STAB && n <= FLT + STAB + 4, 1'b1);
			check(boot_fetch, 1'b1);
			check(boot_vector, 16'hFFFE);
		end else begin
			repeat (4) @(negedge aclk);
			check(cpu_reset_n, 1'b1);
		end
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		@(negedge aclk);
		check({cpu_reset_n, high_osc_run, low_osc_run, sys_clock_sel}, 4'h4);
		@(posedge aclk);
		aresetn <= 1'b1;
		settle(1'b1);
		check(n >= FLT + STAB, 1'b1);
		axi_rd(REG_CTRL, d, r);
		check(d, 32'h0);
		axi_rd(REG_SYSCTL, d, r);
		check(d, 32'h1);
		axi_rd(12'hFFC, d, r);
		check(r, RESP_SLVERR);
		check(d, 32'h0);
		$display("power-on and registers done");
		// Interrupt mode with RAM trapping: decode rows and oscillator writes
		axi_wr(REG_CTRL, 32'h3, r);
		foreach (rows[k]) begin
			if (rows[k].wr) begin
				axi_wr(REG_SYSCTL, {29'h0, rows[k].v[2:0]}, r);
				check(r, RESP_OKAY);
				@(negedge aclk);
				got = {high_osc_run, low_osc_run, sys_clock_sel};
			end else begin
				part.fetch_one(rows[k].v);
				@(negedge aclk);
				irq = trap_irq;
				got = {sfr_hit, dbr_hit, 1'b0};
				@(negedge aclk);
				got[0] = irq | trap_irq;
			end
			settle(rows[k].rst);
			check(got, rows[k].e);
		end
		axi_rd(REG_STATUS, d, r);
		check({d[4], d[0]}, 2'h2);
		axi_wr(REG_STATUS, 32'h3E, r);
		axi_rd(REG_STATUS, d, r);
		check(d, 32'h0);
		// Write with byte 0 not strobed leaves the control register alone
		s_axi_wstrb <= 4'hE;
		axi_wr(REG_CTRL, 32'h0, r);
		axi_rd(REG_CTRL, d, r);
		check(d, 32'h3);
		s_axi_wstrb <= 4'hF;
		$display("table done");
		// Reset mode traps and watchdog
		axi_wr(REG_CTRL, 32'h0, r);
		part.fetch_one(16'h0100);
		settle(1'b0);
		part.fetch_one(16'h0010);
		settle(1'b1);
		axi_wr(REG_CTRL, 32'h1, r);
		part.fetch_one(16'h0100);
		settle(1'b1);
		@(posedge aclk);
		wdog_req <= 1'b1;
		@(posedge aclk);
		wdog_req <= 1'b0;
		settle(1'b1);
		$display("traps done");
		// Clock enable low: a register region fetch is ignored while frozen
		@(posedge aclk);
		ce <= 1'b0;
		part.fetch_one(16'h0010);
		settle(1'b0);
		check(trap_irq, 1'b0);
		@(posedge aclk);
		ce <= 1'b1;
		settle(1'b0);
		$display("clock enable done");
		// Reset pin one cycle short of the minimum, then exactly the minimum
		part.pin_low(11);
		settle(1'b0);
		part.pin_low(12);
		settle(1'b1);
		$display("pin done");
		print_verdict();
	end
endmodule
